//--- eeprom_cmd_pkg.sv
// constants and types shared by the serial eeprom command engine
package eeprom_cmd_pkg;
    localparam int ADDR_W  = 7;
    localparam int DATA_W  = 16;
    localparam int WORDS   = 128;
    localparam int OP_W    = 2;
    localparam int AFLD_W  = 8;
    localparam int HDR_W   = OP_W + AFLD_W;

    localparam logic [3:0] HDR_LAST  = 4'h9;
    localparam logic [3:0] DATA_LAST = 4'hF;
    localparam logic [3:0] CNT_ZERO  = 4'h0;
    localparam logic [3:0] CNT_STEP  = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_STEP = 7'h01;

    localparam logic [1:0] OP_EXT   = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ  = 2'h2;
    localparam logic [1:0] OP_ERASE = 2'h3;
    localparam logic [1:0] EXT_LOCK   = 2'h0;
    localparam logic [1:0] EXT_FILL   = 2'h1;
    localparam logic [1:0] EXT_ERALL  = 2'h2;
    localparam logic [1:0] EXT_UNLOCK = 2'h3;

    localparam logic [DATA_W-1:0] ERASED_WORD = 16'hFFFF;
    localparam logic LOCK_AT_RESET = 1'b1;

    localparam int CLK_PERIOD_NS = 5;
    localparam int NS_PER_MS     = 1000000;
    localparam int PROG_TIME_MS  = 10;
    localparam int PROG_CYCLES_DEF = PROG_TIME_MS * NS_PER_MS / CLK_PERIOD_NS;

    typedef enum logic [2:0] {L_IDLE, L_HDR, L_DATA, L_READ, L_DONE} link_state_t;
    typedef enum logic [1:0] {K_UNLOCK, K_LOCK, K_WRITE, K_FILL} cmd_kind_t;

    typedef struct packed {
        cmd_kind_t         kind;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } cmd_t;
endpackage : eeprom_cmd_pkg

//--- serial_eeprom_command_engine.sv
// command engine of a 128 x 16 serial eeprom
// Overview of operation
// - all input bits taken on clock rise
// - output released whenever select is low
// - two-bit opcode, extended codes in address
// - erase target cells before programming
// - first one after select is start
// - read shifts out addressed 16-bit word
// - dummy zero on last address bit
// - read bits change on clock rise
// - continued clocking reads next addresses
// - power-on reset leaves writes locked
// - unlock holds until lock command or reset
// - reads work locked or unlocked
// - single write stores word msb first
// - programming starts at select fall
// - commands rejected while programming busy
// - status low busy, high ready
// - fill writes all words at once
// - lock command blocks later writes
// - select low aborts unfinished write
// - select low discards partial input
// - ready high later seen as start
`timescale 1ns/1ps
module serial_eeprom_command_engine #(
    parameter int PROG_CYCLES = eeprom_cmd_pkg::PROG_CYCLES_DEF
) (
    input  wire logic CLK_SYS,
    input  wire logic RST_B,
    input  wire logic SERIAL_CLOCK_IN,
    input  wire logic DEVICE_SELECT,
    input  wire logic SERIAL_IN,
    output logic      SERIAL_OUT,
    output logic      SERIAL_OUT_OE
);
    import eeprom_cmd_pkg::*;

    localparam int CNT_W = $clog2(PROG_CYCLES + 1);
    localparam logic [CNT_W-1:0] PROG_LAST = CNT_W'(PROG_CYCLES - 1);
    localparam logic [CNT_W-1:0] PROG_ONE  = CNT_W'(1);

    // written only as busy rises and falls; while busy the link loads it only at a header end and never shifts it out
    logic [DATA_W-1:0] mem [WORDS];

    logic             sys_ready_ff;
    logic             cs_meta_ff;
    logic             cs_sync_ff;
    logic             tgl_meta_ff;
    logic             tgl_sync_ff;
    logic             tgl_seen_ff;
    logic             lock_ff;
    logic             busy_ff;
    logic             pend_ff;
    logic             status_ff;
    logic [CNT_W-1:0] prog_cnt_ff;
    cmd_t             prog_ff;
    logic             new_cmd;
    logic             prog_start;
    logic             prog_end;

    link_state_t       lstate_ff;
    logic [3:0]        bit_cnt_ff;
    logic [HDR_W-1:0]  hdr_ff;
    logic [DATA_W-1:0] dat_ff;
    logic [ADDR_W-1:0] rd_addr_ff;
    logic [DATA_W-1:0] rd_word_ff;
    logic [3:0]        rd_cnt_ff;
    logic              read_bit_ff;
    logic              bmeta_ff;
    logic              bsync_ff;
    cmd_t              post_ff;
    logic              post_tgl_ff;
    logic              link_clr_n;
    logic [HDR_W-1:0]  hdr_full;
    logic [DATA_W-1:0] dat_full;
    logic [ADDR_W-1:0] rd_next;
    logic              post_now;
    cmd_t              post_val;

    // ****************************************
    // system clock side
    // ****************************************

    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            sys_ready_ff <= 1'b0;
        end else begin
            sys_ready_ff <= 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            cs_meta_ff  <= 1'b0;
            cs_sync_ff  <= 1'b0;
            tgl_meta_ff <= 1'b0;
            tgl_sync_ff <= 1'b0;
            tgl_seen_ff <= 1'b0;
        end else begin
            cs_meta_ff  <= DEVICE_SELECT;
            cs_sync_ff  <= cs_meta_ff;
            tgl_meta_ff <= post_tgl_ff;
            tgl_sync_ff <= tgl_meta_ff;
            tgl_seen_ff <= tgl_sync_ff;
        end
    end

    // post_ff has been stable for two cycles when the toggle lands
    assign new_cmd = tgl_sync_ff ^ tgl_seen_ff;
    assign prog_start = pend_ff && !cs_sync_ff && !busy_ff;
    assign prog_end   = busy_ff && (prog_cnt_ff == PROG_LAST);

    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            lock_ff <= LOCK_AT_RESET;
        end else if (new_cmd && !busy_ff) begin
            if (post_ff.kind == K_UNLOCK) begin
                lock_ff <= 1'b0;
            end else if (post_ff.kind == K_LOCK) begin
                lock_ff <= 1'b1;
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            pend_ff <= 1'b0;
            prog_ff <= '0;
        end else if (prog_start) begin
            pend_ff <= 1'b0;
        end else if (new_cmd && !busy_ff) begin
            pend_ff <= !lock_ff &&
                       (post_ff.kind == K_WRITE || post_ff.kind == K_FILL);
            prog_ff <= post_ff;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            busy_ff     <= 1'b0;
            prog_cnt_ff <= '0;
        end else if (prog_start) begin
            busy_ff     <= 1'b1;
            prog_cnt_ff <= '0;
        end else if (prog_end) begin
            busy_ff     <= 1'b0;
        end else if (busy_ff) begin
            prog_cnt_ff <= prog_cnt_ff + PROG_ONE;
        end
    end

    // status stays offered until the next command is posted
    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            status_ff <= 1'b0;
        end else if (prog_start) begin
            status_ff <= 1'b1;
        end else if (new_cmd && !busy_ff) begin
            status_ff <= 1'b0;
        end
    end

    // contents are not reset: the array models nonvolatile cells
    always_ff @(posedge CLK_SYS) begin
        if (prog_start) begin
            for (int i = 0; i < WORDS; i++) begin
                if (prog_ff.kind == K_FILL || prog_ff.addr == ADDR_W'(i)) begin
                    mem[i] <= ERASED_WORD;
                end
            end
        end else if (prog_end) begin
            for (int i = 0; i < WORDS; i++) begin
                if (prog_ff.kind == K_FILL || prog_ff.addr == ADDR_W'(i)) begin
                    mem[i] <= prog_ff.data;
                end
            end
        end
    end

    // ****************************************
    // serial link side
    // ****************************************

    // select low clears the parser at once
    // even with the serial clock stopped
    assign link_clr_n = DEVICE_SELECT && sys_ready_ff;

    assign hdr_full = {hdr_ff[HDR_W-2:0], SERIAL_IN};
    assign dat_full = {dat_ff[DATA_W-2:0], SERIAL_IN};
    assign rd_next  = rd_addr_ff + ADDR_STEP;

    always_ff @(posedge SERIAL_CLOCK_IN or negedge sys_ready_ff) begin
        if (!sys_ready_ff) begin
            bmeta_ff <= 1'b0;
            bsync_ff <= 1'b0;
        end else begin
            bmeta_ff <= busy_ff;
            bsync_ff <= bmeta_ff;
        end
    end

    always_ff @(posedge SERIAL_CLOCK_IN or negedge link_clr_n) begin
        if (!link_clr_n) begin
            lstate_ff  <= L_IDLE;
            bit_cnt_ff <= CNT_ZERO;
            hdr_ff     <= '0;
            dat_ff     <= '0;
        end else begin
            case (lstate_ff)
                L_IDLE: begin
                    if (SERIAL_IN) begin
                        lstate_ff  <= L_HDR;
                        bit_cnt_ff <= CNT_ZERO;
                    end
                end
                L_HDR: begin
                    hdr_ff     <= hdr_full;
                    bit_cnt_ff <= bit_cnt_ff + CNT_STEP;
                    if (bit_cnt_ff == HDR_LAST) begin
                        bit_cnt_ff <= CNT_ZERO;
                        case (hdr_full[HDR_W-1 -: OP_W])
                            OP_READ:  lstate_ff <= bsync_ff ? L_DONE : L_READ;
                            OP_WRITE: lstate_ff <= L_DATA;
                            OP_EXT: begin
                                if (hdr_full[AFLD_W-1 -: 2] == EXT_FILL) begin
                                    lstate_ff <= L_DATA;
                                end else begin
                                    lstate_ff <= L_DONE;
                                end
                            end
                            default:  lstate_ff <= L_DONE;
                        endcase
                    end
                end
                L_DATA: begin
                    dat_ff     <= dat_full;
                    bit_cnt_ff <= bit_cnt_ff + CNT_STEP;
                    if (bit_cnt_ff == DATA_LAST) begin
                        lstate_ff <= L_DONE;
                    end
                end
                L_READ:  lstate_ff <= L_READ;
                L_DONE:  lstate_ff <= L_DONE;
                default: lstate_ff <= L_IDLE;
            endcase
        end
    end

    // a command is posted only when its last bit is in;
    // a select fall before that posts nothing
    always_comb begin
        post_now      = 1'b0;
        post_val      = '0;
        post_val.addr = hdr_full[ADDR_W-1:0];
        if (lstate_ff == L_HDR && bit_cnt_ff == HDR_LAST &&
            hdr_full[HDR_W-1 -: OP_W] == OP_EXT) begin
            if (hdr_full[AFLD_W-1 -: 2] == EXT_UNLOCK) begin
                post_now      = 1'b1;
                post_val.kind = K_UNLOCK;
            end else if (hdr_full[AFLD_W-1 -: 2] == EXT_LOCK) begin
                post_now      = 1'b1;
                post_val.kind = K_LOCK;
            end
        end else if (lstate_ff == L_DATA && bit_cnt_ff == DATA_LAST) begin
            post_now      = 1'b1;
            post_val.addr = hdr_ff[ADDR_W-1:0];
            post_val.data = dat_full;
            if (hdr_ff[HDR_W-1 -: OP_W] == OP_WRITE) begin
                post_val.kind = K_WRITE;
            end else begin
                post_val.kind = K_FILL;
            end
        end
    end

    always_ff @(posedge SERIAL_CLOCK_IN or negedge sys_ready_ff) begin
        if (!sys_ready_ff) begin
            post_ff     <= '0;
            post_tgl_ff <= 1'b0;
        end else if (post_now) begin
            post_ff     <= post_val;
            post_tgl_ff <= !post_tgl_ff;
        end
    end

    // read path: word fetched on the last address bit
    always_ff @(posedge SERIAL_CLOCK_IN or negedge link_clr_n) begin
        if (!link_clr_n) begin
            rd_addr_ff  <= '0;
            rd_word_ff  <= '0;
            rd_cnt_ff   <= CNT_ZERO;
            read_bit_ff <= 1'b0;
        end else if (lstate_ff == L_HDR && bit_cnt_ff == HDR_LAST) begin
            read_bit_ff <= 1'b0;
            rd_addr_ff  <= hdr_full[ADDR_W-1:0];
            rd_word_ff  <= mem[hdr_full[ADDR_W-1:0]];
            rd_cnt_ff   <= CNT_ZERO;
        end else if (lstate_ff == L_READ) begin
            read_bit_ff <= rd_word_ff[DATA_W-1];
            rd_cnt_ff   <= rd_cnt_ff + CNT_STEP;
            if (rd_cnt_ff == DATA_LAST) begin
                rd_addr_ff <= rd_next;
                rd_word_ff <= mem[rd_next];
            end else begin
                rd_word_ff <= {rd_word_ff[DATA_W-2:0], 1'b0};
            end
        end
    end

    // ****************************************
    // output pin
    // ****************************************

    assign SERIAL_OUT_OE = DEVICE_SELECT && sys_ready_ff &&
                           (lstate_ff == L_READ ||
                            (lstate_ff == L_IDLE && status_ff));
    assign SERIAL_OUT = (lstate_ff == L_READ) ? read_bit_ff : !busy_ff;

endmodule : serial_eeprom_command_engine

//--- serial_eeprom_command_engine_chk.sv
// port checker for the serial eeprom command engine, bound to its top
`timescale 1ns/1ps
module serial_eeprom_command_engine_chk #(
    parameter int PROG_CYCLES = eeprom_cmd_pkg::PROG_CYCLES_DEF
) (
    input wire logic CLK_SYS,
    input wire logic RST_B,
    input wire logic SERIAL_CLOCK_IN,
    input wire logic DEVICE_SELECT,
    input wire logic SERIAL_IN,
    input wire logic SERIAL_OUT,
    input wire logic SERIAL_OUT_OE
);
    // ****************
    // link tracking
    // ****************
    logic        go_ff;
    logic        rd_ff;
    logic [5:0]  pos_ff;
    logic [1:0]  clk_hist_ff;
    // wide enough for the full program time, not only the short sim value
    logic [31:0] busy_ff;
    // select low clears the tracker just like the parser
    always_ff @(posedge SERIAL_CLOCK_IN or negedge DEVICE_SELECT) begin
        if (!DEVICE_SELECT) go_ff <= 1'h0;
        else if (!go_ff) go_ff <= SERIAL_IN;
    end
    always_ff @(posedge SERIAL_CLOCK_IN or negedge DEVICE_SELECT) begin
        if (!DEVICE_SELECT) pos_ff <= 6'h00;
        else if (go_ff && pos_ff != 6'h3F) pos_ff <= pos_ff + 6'h01;
    end
    always_ff @(posedge SERIAL_CLOCK_IN or negedge DEVICE_SELECT) begin
        if (!DEVICE_SELECT) rd_ff <= 1'h0;
        else if (go_ff && pos_ff == 6'h00) rd_ff <= SERIAL_IN;
        else if (go_ff && pos_ff == 6'h01) rd_ff <= rd_ff & !SERIAL_IN;
    end
    always_ff @(posedge CLK_SYS) clk_hist_ff <= {clk_hist_ff[0], SERIAL_CLOCK_IN};
    // status only counts before a start bit, reads also drive zeros
    always_ff @(posedge CLK_SYS) begin
        if (SERIAL_OUT_OE && !SERIAL_OUT && !go_ff) busy_ff <= busy_ff + 32'h1;
        else busy_ff <= 32'h0;
    end
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);
    property p_hiz; !DEVICE_SELECT |-> !SERIAL_OUT_OE; endproperty
    a_hiz: assert property (p_hiz) else $error("driving while deselected");
    property p_dummy;
        go_ff && rd_ff && pos_ff == 6'h0A |-> SERIAL_OUT_OE && !SERIAL_OUT;
    endproperty
    a_dummy: assert property (p_dummy) else $error("no dummy zero");
    property p_rd; go_ff && rd_ff && pos_ff > 6'h0A |-> SERIAL_OUT_OE; endproperty
    a_rd: assert property (p_rd) else $error("read data not driven");
    property p_hdr; go_ff && pos_ff < 6'h0A |-> !SERIAL_OUT_OE; endproperty
    a_hdr: assert property (p_hdr) else $error("driving inside header");
    property p_cmd; go_ff && pos_ff > 6'h02 && !rd_ff |-> !SERIAL_OUT_OE; endproperty
    a_cmd: assert property (p_cmd) else $error("driving in non-read command");
    property p_chg;
        go_ff && $past(SERIAL_OUT_OE) && SERIAL_OUT_OE && $changed(SERIAL_OUT)
            |-> SERIAL_CLOCK_IN && !clk_hist_ff[1];
    endproperty
    a_chg: assert property (p_chg) else $error("read bit moved off clock rise");
    property p_ready;
        SERIAL_OUT_OE && SERIAL_OUT && !go_ff |=> !SERIAL_OUT_OE || SERIAL_OUT;
    endproperty
    a_ready: assert property (p_ready) else $error("ready fell back to busy");
    property p_busy; busy_ff <= PROG_CYCLES; endproperty
    a_busy: assert property (p_busy) else $error("busy outlasted program time");
    c_dummy: cover property (go_ff && rd_ff && pos_ff == 6'h0A);
    c_busy: cover property (busy_ff == 32'h0A);
    c_ready: cover property (SERIAL_OUT_OE && SERIAL_OUT && !go_ff);
endmodule : serial_eeprom_command_engine_chk

bind serial_eeprom_command_engine serial_eeprom_command_engine_chk #(.PROG_CYCLES(PROG_CYCLES))
    u_chk (.CLK_SYS, .RST_B, .SERIAL_CLOCK_IN, .DEVICE_SELECT, .SERIAL_IN, .SERIAL_OUT,
    .SERIAL_OUT_OE);

//--- eeprom_host_model.sv
// host model: drives the eeprom link, clock stands still between frames
`timescale 1ns/1ps
module eeprom_host_model (
    output logic      sck,
    output logic      sel,
    output logic      sdi,
    input  wire logic sdo
);
    // ****************
    // link master
    // ****************
    // inputs low in standby
    initial {sck, sel, sdi} = 3'h0;
    task automatic frame(input logic [63:0] bits, input int n, output logic [63:0] rx);
        rx = 64'h0;
        sel <= 1'h1;
        for (int i = n - 1; i >= 0; i--) begin
            sdi <= bits[i];
            #24 rx = {rx[62:0], sdo};
            sck <= 1'h1;
            #24 sck <= 1'h0;
        end
        // data low once the frame is done
        sdi <= 1'h0;
        #48 sel <= 1'h0;
        #48;
    endtask : frame
    // select dropped at ready, no clocks meanwhile
    task automatic poll(output logic first, output int n);
        sel <= 1'h1;
        #10 first = sdo;
        for (n = 0; sdo !== 1'h1 && n < 400; n++) #5;
        sel <= 1'h0;
        #48;
    endtask : poll
endmodule : eeprom_host_model

//--- serial_eeprom_command_engine_tb.sv
// self-checking bench for the serial eeprom command engine
`timescale 1ns/1ps
module serial_eeprom_command_engine_tb;
    import eeprom_cmd_pkg::*;
    // ****************
    // bench
    // ****************
    localparam int PROG = 50;
    logic        clk_sys;
    logic        rst_b;
    logic        sck;
    logic        sel;
    logic        sdi;
    logic        so;
    logic        oe;
    logic [63:0] rx;
    logic        first;
    int          nb;
    int          fails = 0;
    int          n_compared = 0;
    wire         sdo = oe ? so : 1'hZ;
    initial begin
        clk_sys = 1'h0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    serial_eeprom_command_engine #(.PROG_CYCLES(PROG)) dut (.CLK_SYS(clk_sys), .RST_B(rst_b),
        .SERIAL_CLOCK_IN(sck), .DEVICE_SELECT(sel), .SERIAL_IN(sdi), .SERIAL_OUT(so),
        .SERIAL_OUT_OE(oe));
    eeprom_host_model host (.sck(sck), .sel(sel), .sdi(sdi), .sdo(sdo));
    task automatic chk(input string what, input logic [32:0] exp, input logic [32:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            fails++;
        end
    endtask : chk
    task automatic test_done();
        if (fails == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done
    task automatic do_reset();
        @(posedge clk_sys) rst_b <= 1'h0;
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'h1;
        repeat (3) @(posedge clk_sys);
        #1.3;
    endtask : do_reset
    // two leading zeros, then dummy bit and two words
    task automatic rd2(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input string what);
        host.frame({1'h1, 2'h2, 1'h0, a, 33'h0}, 46, rx);
        chk(what, {1'h0, exp}, rx[32:0]);
    endtask : rd2
    task automatic prog_wait(input string what);
        host.poll(first, nb);
        chk(what, 33'h0, {32'h0, first});
        chk(what, 33'h1, {32'h0, nb > PROG / 2 && nb < PROG + 20});
    endtask : prog_wait
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        host.frame({1'h1, 2'h1, 1'h0, a, d}, 27, rx);
    endtask : wr
    task automatic t_fill();
        host.frame({1'h1, 4'h3, 6'h00}, 11, rx);
        host.frame({1'h1, 4'h1, 6'h00, 16'hA5C3}, 27, rx);
        prog_wait("fill status");
        rd2(7'h7F, 32'hA5C3A5C3, "fill wrap");
    endtask : t_fill
    task automatic t_write();
        wr(7'h00, 16'h8001);
        prog_wait("write status");
        wr(7'h01, 16'h4002);
        prog_wait("write status");
        rd2(7'h00, 32'h80014002, "write pair");
        rd2(7'h01, 32'h4002A5C3, "write next");
    endtask : t_write
    task automatic t_abort();
        host.frame({1'h1, 2'h1, 1'h0, 7'h00, 16'h1234} >> 1, 26, rx);
        // erase and erase-all are decoded but must leave the cells alone
        host.frame({1'h1, 2'h3, 1'h0, 7'h00}, 11, rx);
        host.frame({1'h1, 4'h2, 6'h00}, 11, rx);
        rd2(7'h00, 32'h80014002, "abort");
    endtask : t_abort
    task automatic t_lock();
        host.frame({1'h1, 4'h0, 6'h00}, 11, rx);
        wr(7'h00, 16'h0000);
        rd2(7'h00, 32'h80014002, "locked write");
        host.frame({1'h1, 4'h3, 6'h00}, 11, rx);
        do_reset();
        wr(7'h01, 16'h0000);
        rd2(7'h00, 32'h80014002, "write after reset");
    endtask : t_lock
    initial begin
        rst_b = 1'h0;
        do_reset();
        t_fill();
        t_write();
        t_abort();
        t_lock();
        test_done();
    end
    // runs take about 26 us; this cuts a hang short
    initial begin
        #200000;
        fails++;
        test_done();
    end
endmodule : serial_eeprom_command_engine_tb
